// ===== common/dac_ctrl_regs.vh
`ifndef DAC_CTRL_REGS_VH
`define DAC_CTRL_REGS_VH
// address width of the register select pins
`define ADDR_W          5
// reset pulse length in ns and in mclk cycles (100 ns period)
`define RST_PULSE_NS    1000
`define RST_PULSE_CYC   8'h0a
// load pulse length in ns and in cycles
`define LOAD_PULSE_NS   200
`define LOAD_PULSE_CYC  8'h02
// width of the pulse counter
`define CNT_W           8
`endif

// ===== rtl/pulse_timer.v
`include "dac_ctrl_regs.vh"
// one-shot counter: busy for len cycles after start
module pulse_timer
(
  input  wire               mclk_i,
  input  wire               resetn_i,
  input  wire               start_i,
  input  wire [`CNT_W-1:0]  len_i,
  output wire               busy_o
);
  reg [`CNT_W-1:0] count;

  // load on start, count down to zero
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      count <= 8'h00;
    else if (start_i)
      count <= len_i;
    else if (count != 8'h00)
      count <= count - 8'h01;
  end

  assign busy_o = (count != 8'h00);
endmodule // pulse_timer

// ===== rtl/dac_load_reset_control.v
// Behaviour
// - asynchronous mode: latch load held low from before power-up.
// - synchronous mode: latch load held high throughout power-on.
// - chip select stays high whenever hardware reset is used.
// - general-purpose pin is open drain, pulled high externally.
`include "dac_ctrl_regs.vh"
module dac_load_reset_control
(
  input  wire               mclk_i,
  input  wire               resetn_i,
  input  wire               async_mode_i,
  input  wire               load_req_i,
  input  wire               reset_req_i,
  input  wire               reset_level_i,
  input  wire               clear_req_i,
  input  wire               access_req_i,
  input  wire [`ADDR_W-1:0] reg_addr_i,
  input  wire               gpio_drive_low_i,
  output wire               busy_o,
  output reg                gpio_level_o,
  output reg                latch_load_n_o,
  output reg                hw_reset_n_o,
  output reg                reset_level_select_o,
  output reg                clear_outputs_n_o,
  output reg                chip_select_n_o,
  output reg  [`ADDR_W-1:0] addr_o,
  input  wire               gpio_i,
  output wire               gpio_o,
  output reg                gpio_oe_o
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_RESET = 2'b01;
  localparam ST_LOAD  = 2'b10;
  localparam ST_ACC   = 2'b11;

  reg  [1:0]        state;
  reg  [1:0]        next_state;
  reg               start;
  reg  [`CNT_W-1:0] len;
  wire              tbusy;
  reg               load_pulse_n;
  wire              go_reset;
  wire              go_load;
  wire              go_access;

  pulse_timer u_timer
  (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .start_i  (start),
    .len_i    (len),
    .busy_o   (tbusy)
  );

  // request arbitration; reset wins over load and access
  always @*
  begin
    next_state = state;
    start      = 1'b0;
    len        = 8'h00;
    case (state)
      ST_IDLE:
      begin
        if (reset_req_i)
        begin
          next_state = ST_RESET;
          start      = 1'b1;
          len        = `RST_PULSE_CYC;
        end
        else if (load_req_i && !async_mode_i)
        begin
          next_state = ST_LOAD;
          start      = 1'b1;
          len        = `LOAD_PULSE_CYC;
        end
        else if (access_req_i)
          next_state = ST_ACC;
      end
      ST_RESET, ST_LOAD:
        if (!tbusy)
          next_state = ST_IDLE;
      ST_ACC:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // decoded views of the next state; the reset, load and chip select drivers
  // below register one of them so those pins move on the same edge
  assign go_reset  = (next_state == ST_RESET);
  assign go_load   = (next_state == ST_LOAD);
  assign go_access = (next_state == ST_ACC);

  // state register
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // level select is held steady, sampled only when idle, so it
  // cannot change under a running reset pulse
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reset_level_select_o <= 1'b0;
    else if (state == ST_IDLE)
      reset_level_select_o <= reset_level_i;
  end

  // hardware reset pulse; held low while the controller itself is
  // in reset so the device powers up in a known state
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      hw_reset_n_o <= 1'b0;
    else
      hw_reset_n_o <= !go_reset;
  end

  // synchronous load pulse; idles high so sync mode sees load high
  // through power-on
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      load_pulse_n <= 1'b1;
    else
      load_pulse_n <= !go_load;
  end

  // async mode ties load low without a register in the path, so the
  // pin is low during controller reset as well, before the device
  // could leave its power-on state
  always @*
  begin
    latch_load_n_o = load_pulse_n & !async_mode_i;
  end

  // clear outputs level follows the request one cycle later
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      clear_outputs_n_o <= 1'b1;
    else
      clear_outputs_n_o <= !clear_req_i;
  end

  // chip select only for accesses; the access state is never
  // entered during a reset pulse, so select stays high then
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      chip_select_n_o <= 1'b1;
    else
      chip_select_n_o <= !go_access;
  end

  // address is loaded with the select and held afterwards, so it
  // stays stable while chip select rises again
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      addr_o <= 5'h00;
    else if (go_access)
      addr_o <= reg_addr_i;
  end

  // open drain: the enable only ever pulls the pin low
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      gpio_oe_o <= 1'b0;
    else
      gpio_oe_o <= gpio_drive_low_i;
  end

  // pin level sample; resets to the pull-up level
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      gpio_level_o <= 1'b1;
    else
      gpio_level_o <= gpio_i;
  end

  // driven value is always low; the pull-up gives the high level
  assign gpio_o = 1'b0;
  // busy while any pulse or access is running
  assign busy_o = (state != ST_IDLE);
endmodule // dac_load_reset_control

// ===== testbench/dac_ctrl_checker_asserts.sv
module dac_ctrl_checker(input wire logic mclk_i, resetn_i, async_mode_i,
  gpio_drive_low_i, latch_load_n_o, hw_reset_n_o, chip_select_n_o, gpio_oe_o);
  timeunit 1ns / 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  property p_as; async_mode_i[*2] |-> !latch_load_n_o; endproperty
  a_as: assert property (p_as) else $error("load high");
  property p_sy; $rose(resetn_i) && !async_mode_i |-> latch_load_n_o;
  endproperty
  a_sy: assert property (p_sy) else $error("load low");
  property p_cs; !hw_reset_n_o |-> chip_select_n_o; endproperty
  a_cs: assert property (p_cs) else $error("select in reset");
  property p_od; gpio_drive_low_i |=> gpio_oe_o; endproperty
  a_od: assert property (p_od) else $error("pin not pulled");
  property p_rp; $fell(hw_reset_n_o) |-> !hw_reset_n_o[*8]; endproperty
  a_rp: assert property (p_rp) else $error("reset too short");
  property p_c1; $fell(chip_select_n_o) |=> chip_select_n_o; endproperty
  a_c1: assert property (p_c1) else $error("select too long");
  c_r: cover property ($fell(hw_reset_n_o));
  c_c: cover property ($fell(chip_select_n_o));
  c_o: cover property ($rose(gpio_oe_o));
endmodule // dac_ctrl_checker
bind dac_load_reset_control dac_ctrl_checker i_chk(.*);

// ===== testbench/dac_dev_model.sv
module dac_dev_model(input wire logic latch_load_n_o, hw_reset_n_o,
  reset_level_select_o, clear_outputs_n_o, chip_select_n_o, gpio_oe_o,
  input wire logic [4:0] addr_o, output logic vout, gpio_i);
  timeunit 1ns / 1ns;
  logic dreg, latch;
  // access stores the address lsb as data, reset loads the chosen level
  // access data is taken as select rises, when the address is settled
  always @(posedge chip_select_n_o, negedge hw_reset_n_o)
    dreg = hw_reset_n_o ? addr_o[0] : reset_level_select_o;
  always @* if (!latch_load_n_o || !hw_reset_n_o) latch = dreg;
  assign vout = clear_outputs_n_o & latch;
  assign gpio_i = !gpio_oe_o; // pull-up unless pulled low
endmodule // dac_dev_model

// ===== testbench/tb_top.sv
module tb_top;
  timeunit 1ns / 1ns;
  logic mclk_i = 0, resetn_i = 0, async_mode_i = 0, load_req_i = 0;
  logic reset_req_i = 0, reset_level_i = 0, clear_req_i = 0, access_req_i = 0;
  logic gpio_drive_low_i = 0, busy_o, gpio_level_o, gpio_i, gpio_o, vout;
  logic latch_load_n_o, hw_reset_n_o, reset_level_select_o, gpio_oe_o;
  logic clear_outputs_n_o, chip_select_n_o;
  logic [4:0] reg_addr_i = 5'h00, addr_o;
  int failures = 0, n_compared = 0;
  always #50 mclk_i = ~mclk_i;
  dac_load_reset_control i_dut(.*);
  dac_dev_model i_dev(.*);
  task automatic tick(int n); repeat (n) @(posedge mclk_i); endtask
  // compare a settled value, then return on the next rising edge
  task automatic chk(logic [4:0] got, exp);
    n_compared++;
    if (got !== exp) begin failures++; $display("mismatch %0t value", $time); end
    tick(1);
  endtask
  // bounded wait until the controller takes requests again
  task automatic idle;
    @(negedge mclk_i);
    repeat (40) if (busy_o !== 1'b0) @(negedge mclk_i);
    if (busy_o !== 1'b0) begin failures++; $display("mismatch %0t busy", $time); end
    tick(1);
  endtask
  task automatic s_reset(logic lvl);
    reset_level_i <= lvl; tick(2); reset_req_i <= 1; tick(1); reset_req_i <= 0;
    idle; #1 chk(vout, lvl);
  endtask
  task automatic s_update(logic [4:0] a, logic am);
    access_req_i <= 1; reg_addr_i <= a; tick(1); access_req_i <= 0;
    #1 chk(addr_o, a);
    idle; #1 chk(vout, am ? a[0] : !a[0]);
    load_req_i <= 1; tick(1); load_req_i <= 0;
    idle; #1 chk(vout, a[0]);
  endtask
  task automatic end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    tick(2); resetn_i <= 1; idle;
    s_reset(0); s_reset(1); s_update(5'h16, 0); s_update(5'h0b, 0);
    clear_req_i <= 1; gpio_drive_low_i <= 1; tick(2); #1 chk(vout, 0);
    #1 chk(gpio_level_o, 0);
    clear_req_i <= 0; gpio_drive_low_i <= 0; tick(2); #1 chk(vout, 1);
    #1 chk(gpio_level_o, 1);
    resetn_i <= 0; async_mode_i <= 1; tick(2); resetn_i <= 1;
    idle; s_reset(1); s_update(5'h0a, 1);
    end_sim;
  end
  initial begin #200000; failures++; end_sim; end
endmodule // tb_top
